/* File: logic/lbuf_cfg.svh */
`ifndef LBUF_CFG_SVH
`define LBUF_CFG_SVH

// ==========================================================
// array geometry
`define LBUF_DEPTH 910
`define LBUF_PTR_W 10
`define LBUF_DATA_W 8

// ==========================================================
// pointer load and step values
`define LBUF_PTR_ZERO 10'h000
`define LBUF_PTR_LAST 10'h38d
`define LBUF_PTR_ONE 10'h001

// ==========================================================
// pin sample vector layout
`define LBUF_PIN_W 14
`define LBUF_PIN_WCLK 0
`define LBUF_PIN_WCLR_N 1
`define LBUF_PIN_WEN_N 2
`define LBUF_PIN_WDATA_LO 3
`define LBUF_PIN_WDATA_HI 10
`define LBUF_PIN_RCLK 11
`define LBUF_PIN_RCLR_N 12
`define LBUF_PIN_REN_N 13

// ==========================================================
// output buffer
`define LBUF_BUF_DEPTH 2
`define LBUF_DATA_IDLE 8'h00

`endif

/* File: logic/lbuf_pkg.sv */
`include "lbuf_cfg.svh"

package lbuf_pkg;

    typedef logic [`LBUF_PTR_W-1:0] lbuf_ptr_t;
    typedef logic [`LBUF_DATA_W-1:0] lbuf_data_t;
    typedef logic [`LBUF_PIN_W-1:0] lbuf_pins_t;

    typedef struct packed {
        lbuf_pins_t pin_s1;
        lbuf_pins_t pin_s2;
        logic wclk_prev;
        logic rclk_prev;
        lbuf_ptr_t wr_ptr;
        logic wr_pend;
        lbuf_ptr_t wr_pend_addr;
        lbuf_ptr_t rd_ptr;
        logic rd_fly;
        logic oe;
        lbuf_data_t buf0;
        lbuf_data_t buf1;
        logic v0;
        logic v1;
        lbuf_data_t dout;
    } lbuf_state_s;

endpackage

/* File: logic/lbuf_mem.sv */
`timescale 1ns/1ps
`include "lbuf_cfg.svh"

module lbuf_mem
(
    // clock
    input wire logic clock_i,
    // write port
    input wire logic wr_en_i,
    input wire lbuf_pkg::lbuf_ptr_t wr_addr_i,
    input wire lbuf_pkg::lbuf_data_t wr_data_i,
    // read port
    input wire logic rd_en_i,
    input wire lbuf_pkg::lbuf_ptr_t rd_addr_i,
    output lbuf_pkg::lbuf_data_t rd_data_o
);

    // ==========================================================
    // storage, no reset: contents are undefined until written
    lbuf_pkg::lbuf_data_t mem_reg [0:`LBUF_DEPTH-1];
    lbuf_pkg::lbuf_data_t rd_data_reg;

    always_ff @(posedge clock_i)
    begin
        if (wr_en_i)
        begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i)
        begin
            rd_data_reg <= mem_reg[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_reg;

endmodule

/* File: logic/lbuf_top.sv */
`timescale 1ns/1ps
`include "lbuf_cfg.svh"

// Operation
// (RULE1) store 910 words of 8 bits, 8-bit write input and 8-bit read output
// (RULE2) write and read ports run independently and may work at the same time
// (RULE3) write clear sampled low with write enable low loads write pointer 0
// (RULE4) write clear sampled low with write enable high loads write pointer 909
// (RULE5) write clear and write enable sampled on write clock edge starting a cycle
// (RULE6) write data captured on the write clock edge ending the cycle
// (RULE7) write enable low stores every cycle; high stores nothing and holds pointer
// (RULE8) write pointer advances by one each write cycle unless write enable high
// (RULE9) write pointer wraps from 909 to 0
// (RULE10) read clear sampled low with read enable low loads read pointer 0
// (RULE11) read clear sampled low with read enable high loads read pointer 909
// (RULE12) read clock edge sampling controls also starts the read access; the code drops an edge seen while the output buffer is full
// (RULE13) read enable high floats data outputs and stops the read pointer; the code leaves outputs as they are on an edge dropped while full
// (RULE14) read pointer advances by one each read cycle unless read enable high; the code also holds it on an edge dropped while the buffer is full
// (RULE15) read pointer wraps from 909 to 0
// (RULE16) delay line length set by pointer offsets, from 10 up to 910 words
// (RULE17) written word reaches the outputs within half write period plus 300 ns
// (RULE18) outside logic keeps disable, clear and 910 periods within 1 ms
// (RULE19) a sampled clear replaces the normal pointer increment in that cycle

module lbuf_top
(
    // system
    input wire logic clock_i,
    input wire logic arst_n_i,
    // write port pins
    input wire logic wr_clk_i,
    input wire logic wr_ptr_clear_n_i,
    input wire logic wr_en_n_i,
    input wire logic [7:0] wr_data_in_i,
    // read port pins
    input wire logic rd_clk_i,
    input wire logic rd_ptr_clear_n_i,
    input wire logic rd_en_n_i,
    // read data toward downstream logic
    output logic [7:0] rd_data_out_o,
    output logic rd_data_oe_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i
);

    // ==========================================================
    // state
    lbuf_pkg::lbuf_state_s st_reg;
    lbuf_pkg::lbuf_state_s st_next;

    logic mem_we;
    lbuf_pkg::lbuf_ptr_t mem_waddr;
    lbuf_pkg::lbuf_data_t mem_wdata;
    logic mem_re;
    lbuf_pkg::lbuf_ptr_t mem_raddr;
    lbuf_pkg::lbuf_data_t mem_rdata;

    // ==========================================================
    // pointer step with wrap at the last location
    function automatic lbuf_pkg::lbuf_ptr_t ptr_step(input lbuf_pkg::lbuf_ptr_t p);
        lbuf_pkg::lbuf_ptr_t r;
        if (p == `LBUF_PTR_LAST)
        begin
            r = `LBUF_PTR_ZERO; // RULE9 RULE15
        end
        else
        begin
            r = p + `LBUF_PTR_ONE;
        end
        return r;
    endfunction

    // ==========================================================
    // next-state logic
    always_comb
    begin
        logic wedge;
        logic redge;
        logic wclr_n;
        logic wen_n;
        logic rclr_n;
        logic ren_n;
        logic pop;
        logic room;
        lbuf_pkg::lbuf_data_t wdata;

        wedge = 1'b0;
        redge = 1'b0;
        wclr_n = 1'b1;
        wen_n = 1'b1;
        rclr_n = 1'b1;
        ren_n = 1'b1;
        pop = 1'b0;
        room = 1'b0;
        wdata = `LBUF_DATA_IDLE;
        st_next = st_reg;
        mem_we = 1'b0;
        mem_waddr = st_reg.wr_pend_addr;
        mem_wdata = `LBUF_DATA_IDLE;
        mem_re = 1'b0;
        mem_raddr = st_reg.rd_ptr;

        // pins cross two flops before any logic looks at them
        st_next.pin_s1 = {rd_en_n_i, rd_ptr_clear_n_i, rd_clk_i, wr_data_in_i,
                          wr_en_n_i, wr_ptr_clear_n_i, wr_clk_i};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.wclk_prev = st_reg.pin_s2[`LBUF_PIN_WCLK];
        st_next.rclk_prev = st_reg.pin_s2[`LBUF_PIN_RCLK];

        // port clocks become one-cycle enables of clock_i
        wedge = st_reg.pin_s2[`LBUF_PIN_WCLK] & ~st_reg.wclk_prev; // RULE2
        redge = st_reg.pin_s2[`LBUF_PIN_RCLK] & ~st_reg.rclk_prev; // RULE2
        wclr_n = st_reg.pin_s2[`LBUF_PIN_WCLR_N];
        wen_n = st_reg.pin_s2[`LBUF_PIN_WEN_N];
        rclr_n = st_reg.pin_s2[`LBUF_PIN_RCLR_N];
        ren_n = st_reg.pin_s2[`LBUF_PIN_REN_N];
        wdata = st_reg.pin_s2[`LBUF_PIN_WDATA_HI:`LBUF_PIN_WDATA_LO];

        // ======================================================
        // write port
        if (wedge)
        begin
            // data arriving now closes the cycle opened at the previous edge
            if (st_reg.wr_pend)
            begin
                mem_we = 1'b1; // RULE6 RULE1
                mem_waddr = st_reg.wr_pend_addr;
                mem_wdata = wdata;
            end
            // controls sampled now open a new cycle
            if (!wclr_n)
            begin
                st_next.wr_ptr = wen_n ? `LBUF_PTR_LAST : `LBUF_PTR_ZERO; // RULE3 RULE4 RULE19 RULE5
            end
            else if (!wen_n)
            begin
                st_next.wr_ptr = ptr_step(st_reg.wr_ptr); // RULE8
            end
            st_next.wr_pend = ~wen_n; // RULE7
            st_next.wr_pend_addr = st_next.wr_ptr;
        end

        // ======================================================
        // output buffer: pop first, so a full buffer frees a slot at once
        pop = st_reg.v0 & rd_ready_i;
        if (pop)
        begin
            st_next.buf0 = st_reg.buf1;
            st_next.v0 = st_reg.v1;
            st_next.v1 = 1'b0;
        end
        if (st_reg.rd_fly)
        begin
            if (!st_next.v0)
            begin
                st_next.buf0 = mem_rdata;
                st_next.v0 = 1'b1;
            end
            else
            begin
                st_next.buf1 = mem_rdata;
                st_next.v1 = 1'b1;
            end
        end

        // a read edge is taken only when the word it fetches has a slot;
        // an edge seen while full is dropped and the pointer stays put
        room = ({1'b0, st_next.v0} + {1'b0, st_next.v1}) < 2'(`LBUF_BUF_DEPTH);
        st_next.rd_fly = 1'b0;

        // ======================================================
        // read port
        if (redge && room)
        begin
            st_next.oe = ~ren_n; // RULE13
            if (!rclr_n)
            begin
                st_next.rd_ptr = ren_n ? `LBUF_PTR_LAST : `LBUF_PTR_ZERO; // RULE10 RULE11 RULE19
            end
            else if (!ren_n)
            begin
                st_next.rd_ptr = ptr_step(st_reg.rd_ptr); // RULE14
            end
            if (!ren_n)
            begin
                // same edge starts the access at the new address
                mem_re = 1'b1; // RULE12
                mem_raddr = st_next.rd_ptr;
                st_next.rd_fly = 1'b1;
            end
        end

        // floated outputs show idle data, so nothing stale leaks out
        st_next.dout = st_next.oe ? st_next.buf0 : `LBUF_DATA_IDLE; // RULE13
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // storage; latency from pin to output is a few clock_i cycles,
    // far inside the half period plus 300 ns budget
    lbuf_mem u_mem
    (
        .clock_i(clock_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_en_i(mem_re),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_rdata)
    ); // RULE1 RULE17 RULE16

    assign rd_data_out_o = st_reg.dout;
    assign rd_data_oe_o = st_reg.oe;
    assign rd_valid_o = st_reg.v0;

endmodule

/* File: dv/lbuf_monitor.sv */
`timescale 1ns/1ps

module lbuf_monitor
(
    // system
    input wire logic clock_i,
    input wire logic arst_n_i,
    // read port pins
    input wire logic rd_clk_i,
    input wire logic rd_en_n_i,
    // read data toward downstream logic
    input wire logic [7:0] rd_data_out_o,
    input wire logic rd_data_oe_o,
    input wire logic rd_valid_o,
    input wire logic rd_ready_i
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    // ==========================================================
    // read edge and stall steps
    sequence s_rd_on;
        $rose(rd_clk_i) && !rd_en_n_i && !rd_valid_o;
    endsequence
    sequence s_rd_off;
        $rose(rd_clk_i) && rd_en_n_i && !rd_valid_o;
    endsequence
    sequence s_stall;
        rd_valid_o && !rd_ready_i;
    endsequence

    // ==========================================================
    // checks
    a_off_zero: assert property (!rd_data_oe_o |-> rd_data_out_o == 8'h00)
        else $error("data not zero while outputs disabled");
    a_rd_starts: assert property (s_rd_on |-> ##[2:10] rd_valid_o)
        else $error("enabled read edge gave no word");
    a_oe_on: assert property (s_rd_on |-> ##[2:8] rd_data_oe_o)
        else $error("enabled read edge left outputs off");
    a_oe_off: assert property (s_rd_off |-> ##[2:8] !rd_data_oe_o)
        else $error("disabled read edge left outputs on");
    a_word_held: assert property (s_stall |=> rd_valid_o)
        else $error("word lost during stall");
    a_data_held: assert property (s_stall ##1 $stable(rd_data_oe_o) |-> $stable(rd_data_out_o))
        else $error("head word changed during stall");
    a_no_spur: assert property ($rose(rd_valid_o) |-> $past(rd_clk_i, 3))
        else $error("word appeared without read edge");
    a_valid_oe: assert property ($rose(rd_valid_o) |-> rd_data_oe_o)
        else $error("word offered while outputs off");
endmodule

bind lbuf_top lbuf_monitor u_lbuf_monitor (.clock_i(clock_i), .arst_n_i(arst_n_i), .rd_clk_i(rd_clk_i),
    .rd_en_n_i(rd_en_n_i), .rd_data_out_o(rd_data_out_o), .rd_data_oe_o(rd_data_oe_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i));

/* File: dv/lbuf_sink.sv */
`timescale 1ns/1ps

module lbuf_sink
(
    // system
    input wire logic clock_i,
    input wire logic arst_n_i,
    // bench control
    input wire logic stall_i,
    // handshake
    output logic rd_ready_o
);
    int seed = 84795;
    // random gaps so the buffer meets back-pressure, not only a willing reader
    always @(posedge clock_i or negedge arst_n_i)
        if (!arst_n_i)
            rd_ready_o <= 1'b0;
        else
            rd_ready_o <= !stall_i && ($random(seed) % 4 != 0);
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, got, ev) begin checks_done++; if ((got) !== (ev)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ev, got); end end

module tb;
    logic clock_i = 1'b0, arst_n_i = 1'b0, wr_clk_i = 1'b0, wr_ptr_clear_n_i = 1'b1, wr_en_n_i = 1'b1;
    logic rd_clk_i = 1'b0, rd_ptr_clear_n_i = 1'b1, rd_en_n_i = 1'b1, stall = 1'b0, rd_ready_i;
    logic [7:0] wr_data_in_i = 8'h00, rd_data_out_o;
    logic rd_data_oe_o, rd_valid_o;
    int n_errors = 0, checks_done = 0, seed = 84795, wp = 0, rp = 0, wa = 0, wpend = 0, eo = 0, v;
    int mem [910];
    int exp_q [$];

    always #5 clock_i = ~clock_i;

    lbuf_top u_lbuf_top (.clock_i(clock_i), .arst_n_i(arst_n_i), .wr_clk_i(wr_clk_i),
        .wr_ptr_clear_n_i(wr_ptr_clear_n_i), .wr_en_n_i(wr_en_n_i), .wr_data_in_i(wr_data_in_i),
        .rd_clk_i(rd_clk_i), .rd_ptr_clear_n_i(rd_ptr_clear_n_i), .rd_en_n_i(rd_en_n_i),
        .rd_data_out_o(rd_data_out_o), .rd_data_oe_o(rd_data_oe_o), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i));
    lbuf_sink u_lbuf_sink (.clock_i(clock_i), .arst_n_i(arst_n_i), .stall_i(stall), .rd_ready_o(rd_ready_i));

    // ==========================================================
    // port cycles with reference model
    task automatic wcyc(input int c, input int e, input int h);
        @(posedge clock_i);
        wr_ptr_clear_n_i <= c[0];
        wr_en_n_i <= e[0];
        wr_data_in_i <= 8'($random(seed));
        repeat (3) @(posedge clock_i);
        wr_clk_i <= 1'b1;
        if (wpend) mem[wa] = wr_data_in_i;
        if (!c) wp = e ? 909 : 0;
        else if (!e) wp = (wp == 909) ? 0 : wp + 1;
        wpend = !e;
        wa = wp;
        repeat (h) @(posedge clock_i);
        wr_clk_i <= 1'b0;
        repeat (h) @(posedge clock_i);
    endtask

    task automatic rcyc(input int c, input int e, input int h);
        @(posedge clock_i);
        rd_ptr_clear_n_i <= c[0];
        rd_en_n_i <= e[0];
        repeat (3) @(posedge clock_i);
        rd_clk_i <= 1'b1;
        // the design takes the edge three cycles on, counting that edge's pop
        repeat (3) @(posedge clock_i);
        #1;
        // a full buffer drops the whole edge, pointer included
        if (exp_q.size() < 2)
        begin
            if (!c) rp = e ? 909 : 0;
            else if (!e) rp = (rp == 909) ? 0 : rp + 1;
            if (!e) exp_q.push_back(mem[rp]);
            eo = !e;
        end
        repeat (h - 3) @(posedge clock_i);
        rd_clk_i <= 1'b0;
        repeat (h) @(posedge clock_i);
        `CHK("oe", rd_data_oe_o, 1'(eo))
    endtask

    always @(posedge clock_i)
        if (arst_n_i && rd_valid_o && rd_ready_i)
        begin
            if (exp_q.size() == 0) `CHK("spare word", rd_valid_o, 1'b0)
            else
            begin
                v = exp_q.pop_front();
                `CHK("rd data", rd_data_out_o, 8'(v))
            end
        end

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // sequence
    initial
    begin
        repeat (12) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        wcyc(0, 0, 4);
        repeat (910) wcyc(1, 0, 4);
        wcyc(1, 1, 4);
        wcyc(0, 1, 4);
        wcyc(1, 0, 4);
        wcyc(1, 1, 4);
        $display("fill done");
        rcyc(0, 0, 6);
        repeat (911) rcyc(1, 0, 6);
        rcyc(1, 1, 6);
        rcyc(0, 1, 6);
        rcyc(1, 0, 6);
        repeat (40) rcyc(($random(seed) & 7) != 0, ($random(seed) & 3) == 0, 6);
        $display("read sweep done");
        stall <= 1'b1;
        repeat (3) rcyc(1, 0, 6);
        stall <= 1'b0;
        rcyc(1, 0, 6);
        $display("stall done");
        // writes lead reads so each word lands well before its read edge
        fork
            begin
                wcyc(0, 0, 5);
                repeat (60) wcyc(1, 0, 5);
            end
            begin
                repeat (30) @(posedge clock_i);
                rcyc(0, 0, 7);
                repeat (50) rcyc(1, 0, 7);
            end
        join
        repeat (30) @(posedge clock_i);
        $display("delay line done");
        complete_run();
    end

    initial
    begin
        repeat (80000) @(posedge clock_i);
        n_errors++;
        complete_run();
    end
endmodule
